// ===== src/operand_decoder_regs.vh
// Field positions, condition and sub-opcode codes and decrement-jump bank of the operand field decoder
`ifndef OPERAND_DECODER_REGS_VH
`define OPERAND_DECODER_REGS_VH
`define IDX_BIT          7
`define MOD_HI           6
`define MOD_LO           5
`define OFS_HI           4
`define OFS_LO           0
`define CC_HI            11
`define CC_LO            8
`define SUB_HI           2
`define SUB_LO           0
`define GPR_HI           9
`define GPR_LO           8
`define DJNZ_BANK        2'h3
`define MOD_POST_ADD     2'h0
`define MOD_PRE_SUB_WB   2'h1
`define MOD_PRE_ADD      2'h2
`define MOD_PRE_SUB      2'h3
`define CC_ALWAYS        4'h0
`define CC_NC            4'h1
`define CC_C             4'h2
`define CC_Z             4'h3
`define CC_NZ            4'h4
`define CC_OV            4'h5
`define CC_ULE           4'h6
`define CC_UGT           4'h7
`define CC_ZP            4'h8
`define CC_MI            4'h9
`define CC_PL            4'hA
`define CC_ZN            4'hB
`define CC_STACK_FULL    4'hC
`define CC_EXT0          4'hD
`define CC_EXT1          4'hE
`define CC_EXT2          4'hF
`define UNARY_RESERVED   3'h7
`define RET_VIA_LINK     3'h0
`define RET_FROM_STACK   3'h1
`define RET_FROM_IRQ     3'h2
`define RET_IDLE         3'h3
`define RET_BREAK        3'h4
`endif

// ===== src/index_addr_unit.v
// Indexed data address and index update generation
`timescale 1ns/1ps
module index_addr_unit (
  // Index state
  input  wire [7:0]  i_index_high_byte,
  input  wire [7:0]  i_index0_low_byte,
  input  wire [7:0]  i_index1_low_byte,
  // Instruction fields
  input  wire        i_idx_sel,
  input  wire [1:0]  i_mod,
  input  wire [4:0]  i_offset,
  // Results
  output reg  [15:0] o_addr,
  output reg  [15:0] o_index_new,
  output reg         o_index_we
);
`include "operand_decoder_regs.vh"
  wire [15:0] base;
  wire [15:0] ofs_pos;
  wire [15:0] ofs_neg;
  wire [15:0] sum_pos;
  wire [15:0] sum_neg;
  assign base    = {i_index_high_byte, i_idx_sel ? i_index1_low_byte : i_index0_low_byte};
  assign ofs_pos = {11'h000, i_offset};
  assign ofs_neg = {{11{i_offset[4]}}, i_offset};
  assign sum_pos = base + ofs_pos;
  assign sum_neg = base + ofs_neg;
  always @* begin
    o_addr      = base;
    o_index_new = base;
    o_index_we  = 1'b0;
    case (i_mod)
      `MOD_POST_ADD: begin
        o_addr      = base;
        o_index_new = sum_pos;
        o_index_we  = 1'b1;
      end
      `MOD_PRE_SUB_WB: begin
        o_addr      = sum_neg;
        o_index_new = sum_neg;
        o_index_we  = 1'b1;
      end
      `MOD_PRE_ADD: begin
        o_addr = sum_pos;
      end
      default: begin
        o_addr = sum_neg;
      end
    endcase
  end
endmodule

// ===== src/cond_eval.v
// Branch condition evaluation
`timescale 1ns/1ps
module cond_eval (
  // Condition select
  input  wire [3:0] i_branch_condition_field,
  // Flags and conditions
  input  wire       i_carry,
  input  wire       i_zero,
  input  wire       i_overflow,
  input  wire       i_negative,
  input  wire       i_stack_full_cond,
  input  wire [2:0] i_ext_condition_inputs,
  // Result
  output reg        o_taken
);
`include "operand_decoder_regs.vh"
  always @* begin
    case (i_branch_condition_field)
      `CC_ALWAYS:     o_taken = 1'b1;
      `CC_NC:         o_taken = ~i_carry;
      `CC_C:          o_taken = i_carry;
      `CC_Z:          o_taken = i_zero;
      `CC_NZ:         o_taken = ~i_zero;
      `CC_OV:         o_taken = i_overflow;
      `CC_ULE:        o_taken = ~i_carry | i_zero;
      `CC_UGT:        o_taken = i_carry & ~i_zero;
      `CC_ZP:         o_taken = ~i_negative;
      `CC_MI:         o_taken = i_negative;
      `CC_PL:         o_taken = ~i_negative & ~i_zero;
      `CC_ZN:         o_taken = i_zero | i_negative;
      `CC_STACK_FULL: o_taken = i_stack_full_cond;
      `CC_EXT0:       o_taken = i_ext_condition_inputs[0];
      `CC_EXT1:       o_taken = i_ext_condition_inputs[1];
      default:        o_taken = i_ext_condition_inputs[2];
    endcase
  end
endmodule

// ===== src/risc8_operand_field_decoder.v
// Operand sub-field decoder for the 16-bit instruction word
// Operation
// - Index select picks pair zero or one
// - Modification code selects access and update
// - Low byte carry ripples into high byte
// - Codes 0-2: always, carry clear, carry set
// - Codes 3-5: zero, not zero, overflow
// - Codes 6-7: unsigned below-equal, above
// - Codes 8-B: negative and zero tests
// - Code C stack full, D-F external
// - Shift/rotate sub-opcode maps eight operations
// - Unary sub-opcode maps seven, one reserved
// - Return/misc decodes returns and idle op
// - Code 100 decodes as debugger breakpoint
// - Decrement-jump register in bank three, bank output zero in reset
`timescale 1ns/1ps
module risc8_operand_field_decoder (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // Instruction register
  input  wire        i_instr_valid,
  input  wire [15:0] i_instr,
  input  wire        i_is_indexed,
  input  wire        i_is_branch,
  input  wire        i_is_shift_rotate,
  input  wire        i_is_unary,
  input  wire        i_is_return_misc,
  input  wire        i_is_dec_jump_nonzero,
  // Index registers
  input  wire [7:0]  i_index_high_byte,
  input  wire [7:0]  i_index0_low_byte,
  input  wire [7:0]  i_index1_low_byte,
  // Flags and conditions
  input  wire        i_carry,
  input  wire        i_zero,
  input  wire        i_overflow,
  input  wire        i_negative,
  input  wire        i_stack_full_cond,
  input  wire [2:0]  i_ext_condition_inputs,
  // Decode valid
  output reg         o_valid,
  // Indexed access
  output reg  [15:0] o_data_addr,
  output reg  [15:0] o_index_new,
  output reg         o_index_we,
  output reg         o_index_sel,
  // Branch
  output reg         o_cond_true,
  // Shift/rotate one-hot: 0 sla 1 sl 2 rlc 3 rl 4 sra 5 sr 6 rrc 7 rr
  output reg  [7:0]  o_shift_rotate_op,
  // Unary one-hot: 0 inc 1 add_carry_only 2 dec 3 subtract_one_plus_carry 4 com 5 negate_twos 6 invert_plus_carry
  output reg  [6:0]  o_unary_arith_op,
  // Return/misc
  output reg         o_return_via_link,
  output reg         o_return_from_stack,
  output reg         o_return_from_irq,
  output reg         o_idle_op,
  output reg         o_break_op,
  // Decrement-jump register
  output reg  [1:0]  o_djnz_bank,
  output reg  [1:0]  o_djnz_reg,
  // Errors
  output reg         o_invalid
);
`include "operand_decoder_regs.vh"
  // One-hot decode tracker states
  localparam ST_IDLE  = 2'h1;
  localparam ST_VALID = 2'h2;
  wire [15:0] addr_w;
  wire [15:0] idx_new_w;
  wire        idx_we_w;
  wire        taken_w;
  wire [2:0]  sub_w;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [7:0]  shift_d;
  reg  [6:0]  unary_d;
  reg         ret_link_d;
  reg         ret_stack_d;
  reg         ret_irq_d;
  reg         idle_d;
  reg         break_d;
  reg         invalid_d;
  assign sub_w = i_instr[`SUB_HI:`SUB_LO];

  index_addr_unit u_index (
    .i_index_high_byte (i_index_high_byte),
    .i_index0_low_byte (i_index0_low_byte),
    .i_index1_low_byte (i_index1_low_byte),
    .i_idx_sel         (i_instr[`IDX_BIT]),
    .i_mod             (i_instr[`MOD_HI:`MOD_LO]),
    .i_offset          (i_instr[`OFS_HI:`OFS_LO]),
    .o_addr            (addr_w),
    .o_index_new       (idx_new_w),
    .o_index_we        (idx_we_w)
  );

  cond_eval u_cond (
    .i_branch_condition_field (i_instr[`CC_HI:`CC_LO]),
    .i_carry                  (i_carry),
    .i_zero                   (i_zero),
    .i_overflow               (i_overflow),
    .i_negative               (i_negative),
    .i_stack_full_cond        (i_stack_full_cond),
    .i_ext_condition_inputs   (i_ext_condition_inputs),
    .o_taken                  (taken_w)
  );

  always @* begin
    shift_d     = 8'h00;
    unary_d     = 7'h00;
    ret_link_d  = 1'b0;
    ret_stack_d = 1'b0;
    ret_irq_d   = 1'b0;
    idle_d      = 1'b0;
    break_d     = 1'b0;
    invalid_d   = 1'b0;
    if (i_is_shift_rotate) begin
      shift_d = 8'h01 << sub_w;
    end
    if (i_is_unary) begin
      if (sub_w == `UNARY_RESERVED) begin
        invalid_d = 1'b1;
      end else begin
        unary_d = 7'h01 << sub_w;
      end
    end
    if (i_is_return_misc) begin
      case (sub_w)
        `RET_VIA_LINK:   ret_link_d  = 1'b1;
        `RET_FROM_STACK: ret_stack_d = 1'b1;
        `RET_FROM_IRQ:   ret_irq_d   = 1'b1;
        `RET_IDLE:       idle_d      = 1'b1;
        `RET_BREAK:      break_d     = 1'b1;
        default:         invalid_d   = 1'b1;
      endcase
    end
  end

  always @* begin
    case (state_q)
      ST_IDLE:  state_d = i_instr_valid ? ST_VALID : ST_IDLE;
      ST_VALID: state_d = i_instr_valid ? ST_VALID : ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q             <= ST_IDLE;
      o_valid             <= 1'b0;
      o_data_addr         <= 16'h0000;
      o_index_new         <= 16'h0000;
      o_index_we          <= 1'b0;
      o_index_sel         <= 1'b0;
      o_cond_true         <= 1'b0;
      o_shift_rotate_op   <= 8'h00;
      o_unary_arith_op    <= 7'h00;
      o_return_via_link   <= 1'b0;
      o_return_from_stack <= 1'b0;
      o_return_from_irq   <= 1'b0;
      o_idle_op           <= 1'b0;
      o_break_op          <= 1'b0;
      o_djnz_bank         <= 2'h0;
      o_djnz_reg          <= 2'h0;
      o_invalid           <= 1'b0;
    end else begin
      state_q             <= state_d;
      o_valid             <= (state_d == ST_VALID);
      o_data_addr         <= addr_w;
      o_index_new         <= idx_new_w;
      o_index_we          <= i_instr_valid & i_is_indexed & idx_we_w;
      o_index_sel         <= i_instr[`IDX_BIT];
      o_cond_true         <= i_instr_valid & i_is_branch & taken_w;
      o_shift_rotate_op   <= i_instr_valid ? shift_d : 8'h00;
      o_unary_arith_op    <= i_instr_valid ? unary_d : 7'h00;
      o_return_via_link   <= i_instr_valid & ret_link_d;
      o_return_from_stack <= i_instr_valid & ret_stack_d;
      o_return_from_irq   <= i_instr_valid & ret_irq_d;
      o_idle_op           <= i_instr_valid & idle_d;
      o_break_op          <= i_instr_valid & break_d;
      o_djnz_bank         <= `DJNZ_BANK;
      o_djnz_reg          <= i_is_dec_jump_nonzero ? i_instr[`GPR_HI:`GPR_LO] : 2'h0;
      o_invalid           <= i_instr_valid & invalid_d;
    end
  end
endmodule

// ===== tb/decoder_sva.sv
// Concurrent checks on the operand field decoder ports
`timescale 1ns/1ps
module decoder_sva (
  // Clock and reset
  input wire        i_clk,
  input wire        i_reset_n,
  // Instruction
  input wire        i_instr_valid,
  input wire [15:0] i_instr,
  input wire        i_is_indexed,
  input wire        i_is_branch,
  input wire        i_is_shift_rotate,
  input wire        i_is_unary,
  // Index and conditions
  input wire [7:0]  i_index_high_byte,
  input wire [7:0]  i_index0_low_byte,
  input wire [7:0]  i_index1_low_byte,
  input wire [2:0]  i_ext_condition_inputs,
  // Decoder outputs
  input wire [15:0] o_data_addr,
  input wire [15:0] o_index_new,
  input wire        o_index_we,
  input wire        o_cond_true,
  input wire [7:0]  o_shift_rotate_op,
  input wire [6:0]  o_unary_arith_op,
  input wire        o_invalid,
  input wire [1:0]  o_djnz_bank
);
  wire [15:0] base = {i_index_high_byte, i_instr[7] ? i_index1_low_byte : i_index0_low_byte};
  wire        ix   = i_instr_valid & i_is_indexed & (i_instr[6:5] == 2'h0);
  wire        br   = i_instr_valid & i_is_branch;
  wire        pick = i_ext_condition_inputs[i_instr[9:8] - 2'h1];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_index_we_mode: assert property (o_index_we == $past(i_instr_valid & i_is_indexed & ~i_instr[6]))
    else $error("Index write-back enable wrong");
  a_post_add_addr: assert property ($past(ix) |-> o_data_addr == $past(base))
    else $error("Post-add access address wrong");
  a_post_add_carry: assert property ($past(ix) |-> o_index_new == $past(base + i_instr[4:0]))
    else $error("Post-add index update wrong");
  a_cond_always: assert property ($past(br && i_instr[11:8] == 4'h0) |-> o_cond_true)
    else $error("Always condition not taken");
  a_ext_cond_pick: assert property ($past(br && i_instr[11:10] == 2'h3 && i_instr[9:8] != 2'h0)
    |-> o_cond_true == $past(pick))
    else $error("External condition wrong");
  a_shift_one_hot: assert property ($past(i_instr_valid & i_is_shift_rotate)
    |-> o_shift_rotate_op == 8'h01 << $past(i_instr[2:0]))
    else $error("Shift rotate select wrong");
  a_unary_reserved: assert property ($past(i_instr_valid && i_is_unary && i_instr[2:0] == 3'h7)
    |-> o_invalid && o_unary_arith_op == 7'h00)
    else $error("Reserved unary code not refused");
  a_bank_three: assert property ($past(i_reset_n) |-> o_djnz_bank == 2'h3)
    else $error("Decrement-jump bank not three");
  c_write_back: cover property (o_index_we);
  c_invalid: cover property (o_invalid);
  c_ext_taken: cover property ($past(br && i_instr[11:10] == 2'h3) && o_cond_true);
endmodule

// ===== tb/exec_model.sv
// Execute side model: index registers, flags and external conditions
`timescale 1ns/1ps
module exec_model (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // Write-back from decoder
  input  wire        i_index_we,
  input  wire        i_index_sel,
  input  wire [15:0] i_index_new,
  // Index registers and flags
  output reg  [7:0]  o_index_high_byte,
  output reg  [7:0]  o_index0_low_byte,
  output reg  [7:0]  o_index1_low_byte,
  output reg  [7:0]  o_flags
);
  integer seed = 26;
  initial begin
    {o_index_high_byte, o_index0_low_byte, o_index1_low_byte} = 24'h12F0FE;
    o_flags = 8'h00;
  end
  always @(posedge i_clk) begin
    #1;
    o_flags <= $random(seed);
    if (i_reset_n && i_index_we) begin
      o_index_high_byte <= i_index_new[15:8];
      if (i_index_sel) o_index1_low_byte <= i_index_new[7:0];
      else o_index0_low_byte <= i_index_new[7:0];
    end else if (o_flags[7:6] == 2'h0) begin
      {o_index_high_byte, o_index0_low_byte, o_index1_low_byte} <= $random(seed);
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking testbench of the operand field decoder
`timescale 1ns/1ps
module tb;
  reg         i_clk = 1'b0, i_reset_n = 1'b0, i_instr_valid = 1'b0;
  reg  [15:0] i_instr = 16'h0000;
  reg         i_is_indexed = 1'b0, i_is_branch = 1'b0, i_is_shift_rotate = 1'b0;
  reg         i_is_unary = 1'b0, i_is_return_misc = 1'b0, i_is_dec_jump_nonzero = 1'b0;
  wire [7:0]  i_index_high_byte, i_index0_low_byte, i_index1_low_byte, flags;
  wire        i_carry, i_zero, i_overflow, i_negative, i_stack_full_cond;
  wire [2:0]  i_ext_condition_inputs;
  wire        o_valid, o_index_we, o_index_sel, o_cond_true, o_invalid;
  wire        o_return_via_link, o_return_from_stack, o_return_from_irq, o_idle_op, o_break_op;
  wire [15:0] o_data_addr, o_index_new;
  wire [7:0]  o_shift_rotate_op;
  wire [6:0]  o_unary_arith_op;
  wire [1:0]  o_djnz_bank, o_djnz_reg;
  integer     fail_count = 0, checked = 0, seed = 26, n;
  reg  [31:0] r;
  reg  [59:0] want, got;
  reg  [59:0] exp_q[$];
  assign {i_carry, i_zero, i_overflow, i_negative, i_stack_full_cond, i_ext_condition_inputs} = flags;
  always #10 i_clk = ~i_clk;
  risc8_operand_field_decoder risc8_operand_field_decoder_i (
    .i_clk                  (i_clk),
    .i_reset_n              (i_reset_n),
    .i_instr_valid          (i_instr_valid),
    .i_instr                (i_instr),
    .i_is_indexed           (i_is_indexed),
    .i_is_branch            (i_is_branch),
    .i_is_shift_rotate      (i_is_shift_rotate),
    .i_is_unary             (i_is_unary),
    .i_is_return_misc       (i_is_return_misc),
    .i_is_dec_jump_nonzero  (i_is_dec_jump_nonzero),
    .i_index_high_byte      (i_index_high_byte),
    .i_index0_low_byte      (i_index0_low_byte),
    .i_index1_low_byte      (i_index1_low_byte),
    .i_carry                (i_carry),
    .i_zero                 (i_zero),
    .i_overflow             (i_overflow),
    .i_negative             (i_negative),
    .i_stack_full_cond      (i_stack_full_cond),
    .i_ext_condition_inputs (i_ext_condition_inputs),
    .o_valid                (o_valid),
    .o_data_addr            (o_data_addr),
    .o_index_new            (o_index_new),
    .o_index_we             (o_index_we),
    .o_index_sel            (o_index_sel),
    .o_cond_true            (o_cond_true),
    .o_shift_rotate_op      (o_shift_rotate_op),
    .o_unary_arith_op       (o_unary_arith_op),
    .o_return_via_link      (o_return_via_link),
    .o_return_from_stack    (o_return_from_stack),
    .o_return_from_irq      (o_return_from_irq),
    .o_idle_op              (o_idle_op),
    .o_break_op             (o_break_op),
    .o_djnz_bank            (o_djnz_bank),
    .o_djnz_reg             (o_djnz_reg),
    .o_invalid              (o_invalid)
  );
  exec_model exec_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_index_we(o_index_we),
    .i_index_sel(o_index_sel), .i_index_new(o_index_new), .o_index_high_byte(i_index_high_byte),
    .o_index0_low_byte(i_index0_low_byte), .o_index1_low_byte(i_index1_low_byte), .o_flags(flags));
  task note;
    reg [15:0] b, s, u, cv;
    reg [1:0]  m;
    reg [2:0]  k;
    begin
      b = {i_index_high_byte, i_instr[7] ? i_index1_low_byte : i_index0_low_byte};
      u = {11'h000, i_instr[4:0]};
      s = {{11{i_instr[4]}}, i_instr[4:0]};
      m = i_instr[6:5];
      k = i_instr[2:0];
      cv = {i_ext_condition_inputs, i_stack_full_cond, i_zero | i_negative, ~i_negative & ~i_zero, i_negative,
        ~i_negative, i_carry & ~i_zero, ~i_carry | i_zero, i_overflow, ~i_zero, i_zero, i_carry, ~i_carry, 1'b1};
      exp_q.push_back({m == 2'h0 ? b : b + (m[0] ? s : u), m == 2'h0 ? b + u : (m == 2'h1 ? b + s : b),
        i_is_indexed & ~m[1], i_is_branch & cv[i_instr[11:8]], i_is_shift_rotate ? 8'h01 << k : 8'h00,
        i_is_unary && k != 3'h7 ? 7'h01 << k : 7'h00, i_is_return_misc && k < 3'h5 ? 5'h01 << k : 5'h00,
        (i_is_unary && k == 3'h7) || (i_is_return_misc && k > 3'h4), i_is_dec_jump_nonzero ? i_instr[9:8] : 2'h0,
        i_instr[7], 2'h3});
    end
  endtask
  task close_out;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(negedge i_clk) begin
    if (o_valid === 1'b1) begin
      got = {o_data_addr, o_index_new, o_index_we, o_cond_true, o_shift_rotate_op, o_unary_arith_op, o_break_op,
        o_idle_op, o_return_from_irq, o_return_from_stack, o_return_via_link, o_invalid, o_djnz_reg, o_index_sel,
        o_djnz_bank};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : {60{1'bx}};
      checked = checked + 1;
      if (got !== want) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED decode expected %h seen %h", want, got);
      end
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    for (n = 0; n < 2048; n = n + 1) begin
      @(posedge i_clk);
      #1;
      r = $random(seed);
      i_instr = {r[15:12], n[3:0], r[7:3], n[6:4]};
      {i_is_indexed, i_is_branch, i_is_shift_rotate, i_is_unary, i_is_return_misc, i_is_dec_jump_nonzero} = r[21:16];
      i_instr_valid = (n % 8 != 7);
      #1;
      if (i_instr_valid) note;
    end
    @(posedge i_clk);
    #1;
    i_instr_valid = 1'b0;
    for (n = 0; n < 4 && exp_q.size() > 0; n = n + 1) @(posedge i_clk);
    if (exp_q.size() > 0) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED pending expected 0 seen %0d", exp_q.size());
    end
    close_out;
  end
endmodule
bind risc8_operand_field_decoder decoder_sva decoder_sva_i (
  .i_clk                  (i_clk),
  .i_reset_n              (i_reset_n),
  .i_instr_valid          (i_instr_valid),
  .i_instr                (i_instr),
  .i_is_indexed           (i_is_indexed),
  .i_is_branch            (i_is_branch),
  .i_is_shift_rotate      (i_is_shift_rotate),
  .i_is_unary             (i_is_unary),
  .i_index_high_byte      (i_index_high_byte),
  .i_index0_low_byte      (i_index0_low_byte),
  .i_index1_low_byte      (i_index1_low_byte),
  .i_ext_condition_inputs (i_ext_condition_inputs),
  .o_data_addr            (o_data_addr),
  .o_index_new            (o_index_new),
  .o_index_we             (o_index_we),
  .o_cond_true            (o_cond_true),
  .o_shift_rotate_op      (o_shift_rotate_op),
  .o_unary_arith_op       (o_unary_arith_op),
  .o_invalid              (o_invalid),
  .o_djnz_bank            (o_djnz_bank)
);
